// ==== common/pmrf_pkg.sv ====
// shared constants of the panel row feed: geometry, counter widths, reset values.
// assumes nothing of its surroundings; imported whole by every design file.
package pmrf_pkg;

    // **********************************************
    // panel geometry
    // **********************************************
    localparam int PIX_W = 8;
    localparam int PANEL_COLS = 320;
    localparam int COLOR_DOTS = 3;
    localparam int DOTS_PER_ROW = PANEL_COLS * COLOR_DOTS;
    localparam int PANEL_ROWS = 240;
    localparam int DRIVER_BITS = 240;
    localparam int WORDS_PER_DRIVER = DRIVER_BITS / PIX_W;
    localparam int NUM_DRIVERS = DOTS_PER_ROW / DRIVER_BITS;
    localparam int WORDS_PER_ROW = DOTS_PER_ROW / PIX_W;

    // **********************************************
    // counter widths and buffering
    // **********************************************
    localparam int ROW_W = 8;
    localparam int DRV_W = 3;
    localparam int SUB_W = 5;
    localparam int WCNT_W = 7;
    localparam int BUF_DEPTH = 2;

    // **********************************************
    // reset values
    // **********************************************
    localparam logic [ROW_W-1:0] ROW_RST = 8'h00;
    localparam logic [DRV_W-1:0] DRV_RST = 3'h0;
    localparam logic [SUB_W-1:0] SUB_RST = 5'h00;
    localparam logic [WCNT_W-1:0] WCNT_RST = 7'h00;

    typedef logic [PIX_W-1:0] pmrf_word_t;

endpackage : pmrf_pkg

// ==== dv/pmrf_host_model.sv ====
// host timing controller model: shift clock, pixel words, latch, frame start.
// assumes callers invoke its tasks one at a time from the testbench.
`timescale 1ns/1ps
`default_nettype none

module pmrf_host_model
    import pmrf_pkg::*;
(
    output logic sck_out,
    output logic [PIX_W-1:0] data_out,
    output logic latch_out,
    output logic frame_out,
    output logic pol_out
);
    initial begin
        sck_out = 1'b1;
        data_out = 8'h5a;
        latch_out = 1'b0;
        frame_out = 1'b0;
        pol_out = 1'b0;
    end

    // odd step keeps all 120 words of a row distinct
    function automatic logic [PIX_W-1:0] word_of(input int r, input int w);
        return PIX_W'(w * 37 + r * 11 + 5);
    endfunction : word_of

    // shift clock stands high outside rows
    task automatic pulse_sck(input int n);
        repeat (n) begin
            #62.5 sck_out = 1'b0;
            #62.5 sck_out = 1'b1;
        end
    endtask : pulse_sck

    task automatic send_row(input int n, input int r, input logic fs, input logic pol);
        for (int w = 0; w < n; w++) begin
            data_out = word_of(r, w);
            #40 sck_out = 1'b0;
            // hold time over: no stale word left on the bus
            #25 data_out = ~data_out;
            #60 sck_out = 1'b1;
        end
        #150 pol_out = pol;
        #100 latch_out = 1'b1;
        frame_out = fs;
        #250 latch_out = 1'b0;
        #150 frame_out = 1'b0;
        #100;
    endtask : send_row
endmodule : pmrf_host_model

`default_nettype wire

// ==== dv/pmrf_panel_checker.sv ====
// port assertions for the panel row feed, core clock domain only.
// assumes it is bound to pmrf_panel; names match the design ports.
`timescale 1ns/1ps
`default_nettype none

module pmrf_panel_checker
    import pmrf_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic pixel_shift_clock_in,
    input wire logic [PIX_W-1:0] pixel_data_bus_in,
    input wire logic line_latch_pulse_in,
    input wire logic frame_start_pulse_in,
    input wire logic polarity_in,
    input wire logic display_on_control_in,
    input wire logic [DOTS_PER_ROW-1:0] column_drive_out,
    input wire logic [ROW_W-1:0] row_index_out,
    input wire logic row_strobe_out,
    input wire logic frame_start_out,
    input wire logic drive_polarity_out,
    input wire logic display_enable_out,
    input wire logic row_overrun_out,
    input wire logic row_short_out
);
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_strobe_single: assert property (row_strobe_out |=> !row_strobe_out)
        else $error("row strobe longer than one cycle");
    a_latch_answer: assert property ($fell(line_latch_pulse_in) |-> ##[2:12] row_strobe_out)
        else $error("latch fall not answered");
    a_cols_hold: assert property (!row_strobe_out |-> $stable(column_drive_out))
        else $error("columns changed without latch");
    a_frame_row0: assert property (frame_start_out |-> row_strobe_out && row_index_out == 8'h00)
        else $error("frame start off row zero");
    a_row_step: assert property (row_strobe_out && !frame_start_out |->
        row_index_out == $past(row_index_out) + 8'h01)
        else $error("row index did not step");
    a_row_range: assert property (row_index_out < 8'(PANEL_ROWS))
        else $error("row index out of range");
    a_pol_hold: assert property (!row_strobe_out |-> $stable(drive_polarity_out) && $stable(row_index_out))
        else $error("polarity or index moved between latches");
    a_over_short: assert property (row_overrun_out |-> row_short_out)
        else $error("overrun without short flag");
    a_flag_hold: assert property (!row_strobe_out |-> $stable({row_overrun_out, row_short_out}))
        else $error("flags moved between latches");
    a_display_on_control_on: assert property ($rose(display_enable_out) |-> $past(display_on_control_in, 3))
        else $error("display enable rose early");
    a_display_on_control_off: assert property ($fell(display_enable_out) |-> !$past(display_on_control_in, 3))
        else $error("display enable fell early");
endmodule : pmrf_panel_checker

bind pmrf_panel pmrf_panel_checker i_chk (.*);

`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench of pmrf_panel driven by the host model.
// assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pmrf_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic display_on_control_in = 1'b1;
    logic sck, lat, fs, pol;
    logic [PIX_W-1:0] pd;
    logic [DOTS_PER_ROW-1:0] column_drive_out;
    logic [ROW_W-1:0] row_index_out;
    logic row_strobe_out, frame_start_out, drive_polarity_out;
    logic display_enable_out, row_overrun_out, row_short_out;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_strobe = 0;
    int n_fs = 0;
    int cur = 0;

    always #10 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        n_strobe += int'(row_strobe_out === 1'b1);
        n_fs += int'(frame_start_out === 1'b1);
    end

    pmrf_host_model i_host (.sck_out(sck), .data_out(pd), .latch_out(lat), .frame_out(fs), .pol_out(pol));

    pmrf_panel i_dut (.mclk_in, .reset_n_in, .pixel_shift_clock_in(sck), .pixel_data_bus_in(pd),
        .line_latch_pulse_in(lat), .frame_start_pulse_in(fs), .polarity_in(pol), .display_on_control_in,
        .column_drive_out, .row_index_out, .row_strobe_out, .frame_start_out, .drive_polarity_out,
        .display_enable_out, .row_overrun_out, .row_short_out);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        check(row_index_out, 0, "reset index");
        check({row_strobe_out, frame_start_out, drive_polarity_out}, 0, "reset strobes");
        check({display_enable_out, row_overrun_out, row_short_out}, 0, "reset flags");
        check(|column_drive_out, 0, "reset columns");
    endtask : t_reset

    task automatic t_row(input int r, input logic f, input logic p);
        int s;
        int g;
        s = n_strobe;
        g = n_fs;
        i_host.send_row(WORDS_PER_ROW, r, f, p);
        cur = r;
        check(n_strobe - s, 1, "strobe count");
        check(n_fs - g, f, "frame start");
        check(row_index_out, r, "row index");
        check(drive_polarity_out, p, "polarity");
        check({row_overrun_out, row_short_out}, 0, "flags");
        for (int k = 0; k < WORDS_PER_ROW; k++)
            check(column_drive_out[PIX_W*k +: PIX_W], i_host.word_of(r, k), "column word");
    endtask : t_row

    task automatic t_count(input int n);
        i_host.send_row(n, cur + 1, 1'b0, 1'b1);
        cur++;
        check(row_index_out, cur, "index after odd row");
        check(row_overrun_out, n > WORDS_PER_ROW, "overrun");
        check(row_short_out, n != WORDS_PER_ROW, "short");
    endtask : t_count

    task automatic t_wrap();
        int g;
        g = n_fs;
        while (cur < PANEL_ROWS - 1) begin
            i_host.send_row(0, cur + 1, 1'b0, 1'b1);
            cur++;
        end
        check(row_index_out, PANEL_ROWS - 1, "last row");
        i_host.send_row(0, 0, 1'b0, 1'b0);
        cur = 0;
        check(row_index_out, 0, "wrap row");
        check(n_fs - g, 1, "wrap frame start");
    endtask : t_wrap

    task automatic t_display();
        @(posedge mclk_in);
        #2 display_on_control_in = 1'b0;
        repeat (5) @(posedge mclk_in);
        #2 check(display_enable_out, 0, "display off");
        display_on_control_in = 1'b1;
        repeat (5) @(posedge mclk_in);
        #2 check(display_enable_out, 1, "display on");
    endtask : t_display

    initial begin
        fork
            i_host.pulse_sck(3);
        join_none
        repeat (20) @(posedge mclk_in);
        #2 t_reset();
        reset_n_in = 1'b1;
        i_host.pulse_sck(3);
        repeat (4) @(posedge mclk_in);
        // throwaway row clears whatever the start-up pulses left behind
        i_host.send_row(0, 0, 1'b0, 1'b0);
        t_row(0, 1'b1, 1'b1);
        t_row(1, 1'b0, 1'b1);
        t_count(WORDS_PER_ROW + 1);
        t_count(WORDS_PER_ROW - 1);
        t_wrap();
        t_row(0, 1'b1, 1'b0);
        t_display();
        give_verdict();
    end

    // about 250 us of traffic expected
    initial begin
        #800000;
        n_mismatch++;
        give_verdict();
    end
endmodule : testbench

`default_nettype wire

// ==== rtl/pmrf_panel.sv ====
// row feed of a passive-matrix colour panel: takes pixel words on the host's
// shift clock, fills four column drivers in turn, latches a row on the line
// pulse falling edge and steps the row scan.
// assumes the host keeps all link timing; the shift clock may stop between rows.
`timescale 1ns/1ps
`default_nettype none

module pmrf_panel
    import pmrf_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic pixel_shift_clock_in,
    input wire logic [PIX_W-1:0] pixel_data_bus_in,
    input wire logic line_latch_pulse_in,
    input wire logic frame_start_pulse_in,
    input wire logic polarity_in,
    input wire logic display_on_control_in,
    output logic [DOTS_PER_ROW-1:0] column_drive_out,
    output logic [ROW_W-1:0] row_index_out,
    output logic row_strobe_out,
    output logic frame_start_out,
    output logic drive_polarity_out,
    output logic display_enable_out,
    output logic row_overrun_out,
    output logic row_short_out
);

    // **********************************************
    // link side state, clocked by the host shift clock
    // **********************************************
    // two slots alternate so a word stays put for two shift clocks after
    // its pointer flips, which gives the core ample time to read it
    typedef struct packed {
        logic [1:0] rst_sync;
        logic wp;
        logic [1:0][PIX_W-1:0] slot;
    } pmrf_link_t;

    // **********************************************
    // core side state, clocked by mclk_in
    // **********************************************
    typedef struct packed {
        logic [1:0] wp_sync;
        logic rp;
        logic [2:0] lp_sync;
        logic [1:0] fs_sync;
        logic [1:0] pol_sync;
        logic [1:0] display_on_control_sync;
        logic latch_pend;
        logic fs_cap;
        logic pol_cap;
        logic [DRV_W-1:0] drv;
        logic [SUB_W-1:0] sub;
        logic [WCNT_W-1:0] wcnt;
        logic sel_gap;
        logic ovf;
        logic [NUM_DRIVERS-1:0][DRIVER_BITS-1:0] sreg;
        logic [NUM_DRIVERS-1:0][DRIVER_BITS-1:0] cols;
        logic [ROW_W-1:0] row;
        logic row_strobe;
        logic frame_strobe;
        logic pol;
        logic display_on_control;
        logic ovf_rep;
        logic short_rep;
    } pmrf_core_t;

    pmrf_link_t link;
    pmrf_link_t next_link;
    pmrf_core_t st;
    pmrf_core_t next_st;

    logic avail;
    logic push;
    logic buf_in_ready;
    logic buf_out_valid;
    pmrf_word_t buf_out_data;
    logic drain_ready;
    logic drain_fire;
    logic latch_now;
    logic lp_fall;
    logic lp_rise;
    logic [ROW_W-1:0] row_step;
    logic [NUM_DRIVERS-1:0] drv_we;
    logic [NUM_DRIVERS-1:0][DRIVER_BITS-1:0] drv_shift;

    // **********************************************
    // link domain: word capture on the shift clock falling edge
    // **********************************************
    // the reset is brought in through two flops of this domain; it needs a
    // few shift clock edges to take effect, as the link has no reset pin
    always_comb begin
        next_link = link;
        next_link.rst_sync = {link.rst_sync[0], reset_n_in};
        if (!link.rst_sync[1]) begin
            next_link.wp = 1'b0;
        end else begin
            next_link.slot[link.wp] = pixel_data_bus_in;
            next_link.wp = ~link.wp;
        end
    end

    always_ff @(negedge pixel_shift_clock_in) begin
        link <= next_link;
    end

    // **********************************************
    // crossing into the core domain
    // **********************************************
    // the word is read only once the synchronised pointer says it is settled
    assign avail = (st.wp_sync[1] != st.rp);
    assign push = avail & buf_in_ready;

    pmrf_row_buf #(
        .WIDTH(PIX_W),
        .DEPTH(BUF_DEPTH)
    ) u_row_buf (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(avail),
        .in_data_in(link.slot[st.rp]),
        .in_ready_out(buf_in_ready),
        .out_valid_out(buf_out_valid),
        .out_data_out(buf_out_data),
        .out_ready_in(drain_ready)
    );

    // **********************************************
    // line pulse edges, seen after the synchroniser
    // **********************************************
    assign lp_fall = st.lp_sync[2] & ~st.lp_sync[1];
    assign lp_rise = ~st.lp_sync[2] & st.lp_sync[1];

    // a driver switch costs one idle cycle while the select moves over;
    // words arriving meanwhile wait in the buffer
    assign drain_ready = ~st.sel_gap;
    assign drain_fire = buf_out_valid & drain_ready;

    // the latch waits until every word of the row has left the crossing
    // and the buffer, so a row is never split by the latch
    assign latch_now = st.latch_pend & ~avail & ~buf_out_valid;

    // **********************************************
    // row scan step
    // **********************************************
    // a frame start seen at the latch wins over the wrap, so a host that
    // restarts a frame early is followed at once
    assign row_step = st.fs_cap ? ROW_RST :
                      (st.row == ROW_W'(PANEL_ROWS - 1)) ? ROW_RST : st.row + 1'b1;

    // **********************************************
    // column drivers: select decode and shift per driver
    // **********************************************
    genvar g;
    generate
        for (g = 0; g < NUM_DRIVERS; g++) begin : g_drv
            assign drv_we[g] = drain_fire & (st.drv == DRV_W'(g));
            // first word of a driver ends up in the low bits after 30 shifts
            assign drv_shift[g] = {buf_out_data, st.sreg[g][DRIVER_BITS-1:PIX_W]};
        end
    endgenerate

    // **********************************************
    // core next state
    // **********************************************
    always_comb begin
        next_st = st;

        // **********************************************
        // synchronisers
        // **********************************************
        // the line pulse has a third flop so both of its edges are judged
        // between two settled copies, never on the metastable first stage
        next_st.wp_sync = {st.wp_sync[0], link.wp};
        next_st.lp_sync = {st.lp_sync[1:0], line_latch_pulse_in};
        next_st.fs_sync = {st.fs_sync[0], frame_start_pulse_in};
        next_st.pol_sync = {st.pol_sync[0], polarity_in};
        next_st.display_on_control_sync = {st.display_on_control_sync[0], display_on_control_in};
        next_st.display_on_control = st.display_on_control_sync[1];

        // **********************************************
        // one-cycle strobes
        // **********************************************
        next_st.row_strobe = 1'b0;
        next_st.frame_strobe = 1'b0;
        next_st.sel_gap = 1'b0;

        // **********************************************
        // word crossing
        // **********************************************
        if (push) begin
            next_st.rp = ~st.rp;
        end

        // **********************************************
        // latch pulse capture
        // **********************************************
        // polarity is taken while the latch pulse is high, since it may
        // change shortly after the falling edge
        if (lp_rise) begin
            next_st.pol_cap = st.pol_sync[1];
        end
        if (lp_fall) begin
            next_st.latch_pend = 1'b1;
            next_st.fs_cap = st.fs_sync[1];
        end

        // **********************************************
        // column driver fill
        // **********************************************
        for (int i = 0; i < NUM_DRIVERS; i++) begin
            if (drv_we[i]) begin
                next_st.sreg[i] = drv_shift[i];
            end
        end

        if (drain_fire) begin
            if (st.drv < DRV_W'(NUM_DRIVERS)) begin
                next_st.wcnt = st.wcnt + 1'b1;
                if (st.sub == SUB_W'(WORDS_PER_DRIVER - 1)) begin
                    next_st.sub = SUB_RST;
                    next_st.drv = st.drv + 1'b1;
                    next_st.sel_gap = 1'b1;
                end else begin
                    next_st.sub = st.sub + 1'b1;
                end
            end else begin
                // words beyond a full row have no driver to go to
                next_st.ovf = 1'b1;
            end
        end

        // **********************************************
        // row latch
        // **********************************************
        // the row on display stays until this point while the next shifts in
        if (latch_now) begin
            // a fall landing in the latch cycle itself must not be lost
            next_st.latch_pend = lp_fall;
            next_st.cols = st.sreg;
            next_st.row = row_step;
            next_st.row_strobe = 1'b1;
            next_st.frame_strobe = (row_step == ROW_RST);
            next_st.pol = st.pol_cap;
            next_st.ovf_rep = st.ovf;
            // an overrun row has no exact count, so it is short as well
            next_st.short_rep = (st.wcnt != WCNT_W'(WORDS_PER_ROW)) | st.ovf;
            next_st.ovf = 1'b0;
            next_st.drv = DRV_RST;
            next_st.sub = SUB_RST;
            next_st.wcnt = WCNT_RST;
        end

        // **********************************************
        // reset
        // **********************************************
        if (!reset_n_in) begin
            next_st = '0;
            next_st.row = ROW_RST;
            next_st.drv = DRV_RST;
            next_st.sub = SUB_RST;
            next_st.wcnt = WCNT_RST;
        end
    end

    always_ff @(posedge mclk_in) begin
        st <= next_st;
    end

    // **********************************************
    // outputs, all straight from flops
    // **********************************************
    assign column_drive_out = st.cols;
    assign row_index_out = st.row;
    assign row_strobe_out = st.row_strobe;
    assign frame_start_out = st.frame_strobe;
    assign drive_polarity_out = st.pol;
    // blanking is left to the drive stage; the latched row is kept intact
    assign display_enable_out = st.display_on_control;
    // the flags describe the row now on display, not the one shifting in
    assign row_overrun_out = st.ovf_rep;
    assign row_short_out = st.short_rep;

endmodule : pmrf_panel

`default_nettype wire

// ==== rtl/pmrf_row_buf.sv ====
// small fifo with valid/ready on both sides, holding pixel words on their way
// from the clock crossing to the column driver shift registers.
// assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module pmrf_row_buf
    import pmrf_pkg::*;
#(
    parameter int WIDTH = PIX_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } pmrf_buf_t;

    pmrf_buf_t st;
    pmrf_buf_t next_st;
    logic push;
    logic pop;

    assign in_ready_out = (st.count != (AW+1)'(DEPTH));
    assign out_valid_out = (st.count != '0);
    assign out_data_out = st.mem[st.rd];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        if (!reset_n_in) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk_in) begin
        st <= next_st;
    end

endmodule : pmrf_row_buf

`default_nettype wire
